// File: dv/starter_overload_process_io_bench.sv
// Self-checking bench for the soft-starter process-data block.
// Assumes the host model drives the register bus; ramp shortened to 8 cycles.
`timescale 1ns/100ps
`include "starter_defines.svh"
module starter_overload_process_io_bench;
  logic core_clk_i, nrst_i, cyc, stb, we, ack, irq_o, power_on_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int num_errors = 0;
  int check_count = 0;

  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  wb_host_model i_host (.clk_i(core_clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  starter_overload_process_io #(.RAMP_CYCLES(8)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq_o), .power_on_o(power_on_o));

  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    bit ok;
    i_host.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      num_errors++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask

  // Lets state and interrupt updates land before looking at the pins
  task automatic pins(input logic p, input logic i);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("power_on", {31'h0, p}, {31'h0, power_on_o});
    chk("irq", {31'h0, i}, {31'h0, irq_o});
  endtask

  initial
  begin
    logic [31:0] q;
    int k;
    nrst_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    pins(1'b0, 1'b0);
    rd("status", `OFS_STATUS_BYTE, 32'h0000_0000);
    rd("in0", `OFS_IN_BYTE0, 32'h0000_0000);
    rd("unmapped", 8'h30, 32'h0000_0000);
    wr(`OFS_PLANT, 8'h02);
    wr(`OFS_CTRL_BYTE, 8'h05);
    rd("status nolimit", `OFS_STATUS_BYTE, 32'h0000_000C);
    wr(`OFS_CTRL_BYTE, 8'h01);
    pins(1'b0, 1'b0);
    wr(`OFS_PARAM, 8'h01);
    wr(`OFS_CTRL_BYTE, 8'h05);
    rd("status ramp", `OFS_STATUS_BYTE, 32'h0000_002C);
    q = 32'h0;
    for (k = 0; k < 20 && q[4] !== 1'b1; k++)
      acc(1'b0, `OFS_STATUS_BYTE, 8'h00, q);
    chk("status top", 32'h0000_001C, q);
    rd("irq ramp", `OFS_IRQ_STAT, 32'h0000_0004);
    wr(`OFS_IRQ_STAT, 8'h04);
    rd("irq ramp clr", `OFS_IRQ_STAT, 32'h0000_0000);
    wr(`OFS_PLANT, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h01);
    wr(`OFS_OUT_BYTE0, 8'h0D);
    wr(`OFS_THERMAL, 8'h6E);
    pins(1'b0, 1'b1);
    rd("in1 auto", `OFS_IN_BYTE1, 32'h0000_0050);
    wr(`OFS_THERMAL, 8'h63);
    wr(`OFS_IRQ_STAT, 8'h01);
    pins(1'b1, 1'b0);
    rd("in1 released", `OFS_IN_BYTE1, 32'h0000_0000);
    wr(`OFS_IRQ_MASK, 8'h02);
    wr(`OFS_OUT_BYTE0, 8'h04);
    wr(`OFS_THERMAL, 8'h6E);
    wr(`OFS_THERMAL, 8'h63);
    pins(1'b0, 1'b0);
    rd("in1 manual", `OFS_IN_BYTE1, 32'h0000_00D0);
    wr(`OFS_CTRL_BYTE, 8'h04);
    rd("in1 acked", `OFS_IN_BYTE1, 32'h0000_0000);
    wr(`OFS_CTRL_BYTE, 8'h0D);
    pins(1'b1, 1'b0);
    wr(`OFS_PLANT, 8'h05);
    pins(1'b1, 1'b1);
    wr(`OFS_PLANT, 8'h01);
    rd("status fault", `OFS_STATUS_BYTE, 32'h0000_001F);
    wr(`OFS_CTRL_BYTE, 8'h05);
    wr(`OFS_CTRL_BYTE, 8'h0D);
    wr(`OFS_IRQ_STAT, 8'h02);
    rd("status acked", `OFS_STATUS_BYTE, 32'h0000_001E);
    pins(1'b1, 1'b0);
    results();
  end
endmodule // starter_overload_process_io_bench

// File: dv/wb_host_model.sv
// Classic Wishbone host model standing in for the bus controller.
// Assumes one clock; the bench calls xfer, which holds each request until ack or for at most 40 cycles.
`timescale 1ns/100ps
module wb_host_model
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= {24'h00_0000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 40);
    ok = (ack_i === 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released lines show stale-looking garbage, not the last value
    adr_o <= ~a;
    dat_o <= ~dat_o;
  endtask
endmodule // wb_host_model

// File: verilog/edge_detect.sv
// Rising-edge detector for one synchronous level.
// Assumes the input is already in the core clock domain.
`timescale 1ns/100ps
module edge_detect
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic level_i,
  output logic rise_o
);
  logic last;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      last <= 1'b0;
    else
      last <= level_i;
  end

  assign rise_o = level_i & ~last;
endmodule // edge_detect

// File: verilog/starter_defines.svh
// Constants for the soft-starter process-data block: register offsets, field positions, thermal thresholds, timing.
// Included by the bench and by the design module starter_overload_process_io.
`ifndef STARTER_DEFINES_SVH
`define STARTER_DEFINES_SVH
`define OFS_OUT_BYTE0 8'h00
`define OFS_CTRL_BYTE 8'h04
`define OFS_PARAM 8'h08
`define OFS_THERMAL 8'h0C
`define OFS_PLANT 8'h10
`define OFS_IN_BYTE0 8'h14
`define OFS_IN_BYTE1 8'h18
`define OFS_STATUS_BYTE 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_MASK 8'h24
`define OUT0_RELAY_EN 2
`define OUT0_AUTO_SEL 3
`define CTRL_SETPOINT 0
`define CTRL_OP_RELEASE 2
`define CTRL_FAULT_ACK 3
`define ST_ERROR 0
`define ST_WARNING 1
`define ST_SWITCHED_ON 2
`define ST_POWER 3
`define ST_RAMP_TOP 4
`define ST_CUR_LIMIT 5
`define IN1_ACK_REQ 7
`define THERM_RELEASE 8'd100
`define THERM_TRIP 8'd110
`define TRIP_CODE_OVERLOAD 3'h5
`define RAMP_TIME_US 1000
`define CLK_MHZ 50
`define RAMP_CYCLES (`RAMP_TIME_US * `CLK_MHZ)
`endif

// File: verilog/starter_overload_process_io.sv
// Soft-starter process-data block: overload relay, extended status byte, control byte.
// Classic Wishbone slave, one clock, thermal image written by the breaker side as a register.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "starter_defines.svh"
module starter_overload_process_io
  import starter_pkg::*;
#(
  parameter int RAMP_CYCLES = `RAMP_CYCLES
)
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic power_on_o
);
  logic [7:0] out_byte0;
  logic [7:0] ctrl_byte;
  logic [7:0] thermal;
  logic [3:0] plant;
  logic param_681;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic ack_req;
  logic overload;
  logic fault;
  logic ramp_top;
  logic [31:0] ramp_cnt;
  motor_state_t state;
  motor_state_t next_state;

  // Wishbone decode; answer one cycle after the request, unmapped reads return zero
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire wr_out0 = wr & (wb_adr_i == `OFS_OUT_BYTE0);
  wire wr_ctrl = wr & (wb_adr_i == `OFS_CTRL_BYTE);
  wire wr_param = wr & (wb_adr_i == `OFS_PARAM);
  wire wr_therm = wr & (wb_adr_i == `OFS_THERMAL);
  wire wr_plant = wr & (wb_adr_i == `OFS_PLANT);
  wire wr_istat = wr & (wb_adr_i == `OFS_IRQ_STAT);
  wire wr_imask = wr & (wb_adr_i == `OFS_IRQ_MASK);

  // Bit 0 of output byte 0 has no meaning here
  wire relay_en = out_byte0[`OUT0_RELAY_EN];
  wire auto_sel = out_byte0[`OUT0_AUTO_SEL];
  wire setpoint = ctrl_byte[`CTRL_SETPOINT];
  wire op_release = ctrl_byte[`CTRL_OP_RELEASE];
  wire ack_rise;
  wire hot = thermal >= `THERM_RELEASE;
  wire trip_reached = relay_en & (thermal >= `THERM_TRIP);
  // Leaving trip and clearing the overload latch need cool and no acknowledge pending
  wire release_ok = ~hot & ~ack_req;

  edge_detect u_ack_edge
  (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .level_i(ctrl_byte[`CTRL_FAULT_ACK]),
    .rise_o(ack_rise)
  );

  // Bits 2 and 3 both follow the motor drive; this block has no separate ready state
  wire cur_limit = plant[1] & param_681 & (state == MOT_RAMP);
  wire warn = plant[0] | hot;
  wire [7:0] status_byte = {2'b00, cur_limit, ramp_top, state == MOT_RUN || state == MOT_RAMP,
                            state != MOT_OFF && state != MOT_TRIP, warn, fault};
  wire [7:0] in_byte1 = {ack_req, overload ? `TRIP_CODE_OVERLOAD : 3'h0, 4'h0};
  wire [7:0] in_byte0 = {7'h00, 1'b0};

  // A fault only blocks a new start; a running motor keeps going until told to stop
  always_comb
  begin
    next_state = state;
    unique case (state)
      MOT_OFF: if (setpoint && op_release && !overload && !fault) next_state = MOT_RAMP;
      MOT_RAMP:
        if (!op_release) next_state = MOT_OFF;
        else if (trip_reached) next_state = MOT_TRIP;
        else if (!setpoint) next_state = MOT_OFF;
        else if (ramp_top) next_state = MOT_RUN;
      MOT_RUN:
        if (!op_release) next_state = MOT_OFF;
        else if (trip_reached) next_state = MOT_TRIP;
        else if (!setpoint) next_state = MOT_OFF;
      MOT_TRIP: if (release_ok) next_state = MOT_OFF;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      out_byte0 <= 8'h00;
      ctrl_byte <= 8'h00;
      thermal <= 8'h00;
      plant <= 4'h0;
      param_681 <= 1'b0;
      irq_mask <= 3'h0;
    end
    else
    begin
      if (wr_out0) out_byte0 <= wb_dat_i[7:0];
      if (wr_ctrl) ctrl_byte <= wb_dat_i[7:0];
      if (wr_therm) thermal <= wb_dat_i[7:0];
      if (wr_plant) plant <= wb_dat_i[3:0];
      if (wr_param) param_681 <= wb_dat_i[0];
      if (wr_imask) irq_mask <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= MOT_OFF;
      ramp_cnt <= 32'h0000_0000;
      ramp_top <= 1'b0;
    end
    else
    begin
      // Counter parks at its end value, so ramp_top holds through the run state
      state <= next_state;
      if (state != MOT_RAMP && state != MOT_RUN)
      begin
        ramp_cnt <= 32'h0000_0000;
        ramp_top <= 1'b0;
      end
      else if (ramp_cnt >= 32'(RAMP_CYCLES - 1))
        ramp_top <= 1'b1;
      else
        ramp_cnt <= ramp_cnt + 32'h0000_0001;
    end
  end

  // Overload latch, acknowledge flag and fault, with manual acknowledge paths
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      overload <= 1'b0;
      ack_req <= 1'b0;
      fault <= 1'b0;
    end
    else
    begin
      if (trip_reached)
        overload <= 1'b1;
      else if (release_ok)
        overload <= 1'b0;
      if (auto_sel)
        ack_req <= 1'b0;
      else if (trip_reached)
        ack_req <= 1'b1;
      else if (!setpoint)
        ack_req <= 1'b0;
      if (plant[2])
        fault <= 1'b1;
      else if (ack_rise)
        fault <= 1'b0;
    end
  end

  // Events: overload trip, fault raised, ramp top reached; set wins over write-one-clear
  // Each event is a one-cycle pulse, so a write-one-clear sticks once the event has passed
  wire [2:0] events = {(state == MOT_RAMP) & ~ramp_top & (ramp_cnt >= 32'(RAMP_CYCLES - 1)),
                       plant[2] & ~fault, trip_reached & ~overload};
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_stat <= 3'h0;
    else
      irq_stat <= (irq_stat & ~(wr_istat ? wb_dat_i[2:0] : 3'h0)) | events;
  end

  assign irq_o = |(irq_stat & irq_mask);
  assign power_on_o = (state == MOT_RAMP) || (state == MOT_RUN);

  wire [7:0] rd_byte =
    (wb_adr_i == `OFS_OUT_BYTE0) ? out_byte0 :
    (wb_adr_i == `OFS_CTRL_BYTE) ? ctrl_byte :
    (wb_adr_i == `OFS_PARAM) ? {7'h00, param_681} :
    (wb_adr_i == `OFS_THERMAL) ? thermal :
    (wb_adr_i == `OFS_PLANT) ? {4'h0, plant} :
    (wb_adr_i == `OFS_IN_BYTE0) ? in_byte0 :
    (wb_adr_i == `OFS_IN_BYTE1) ? in_byte1 :
    (wb_adr_i == `OFS_STATUS_BYTE) ? status_byte :
    (wb_adr_i == `OFS_IRQ_STAT) ? {5'h00, irq_stat} :
    (wb_adr_i == `OFS_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  sequence trip_seen_s;
    state == MOT_RUN && trip_reached;
  endsequence
  sequence cooled_s;
    state == MOT_TRIP && release_ok && auto_sel;
  endsequence

  auto_ready_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cooled_s |=> state == MOT_OFF) else $error("no release after cooling");
  auto_restart_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cooled_s ##1 (setpoint && op_release && !fault && !overload) |=> state == MOT_RAMP)
    else $error("no automatic restart");
  ack_auto_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(auto_sel) |-> !ack_req) else $error("ack flag in auto mode");
  status_hi_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    status_byte[7:6] == 2'b00 && in_byte0[0] == 1'b0) else $error("unused bits set");
  ramp_top_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state == MOT_OFF |=> !ramp_top) else $error("ramp top while off");
  cur_limit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !param_681 |-> !status_byte[`ST_CUR_LIMIT]) else $error("limit bit without parameter");
  op_cut_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (power_on_o && !op_release) |=> !power_on_o) else $error("no immediate stop");
  trip_off_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    trip_seen_s |=> state == MOT_TRIP ##0 in_byte1[6:4] == `TRIP_CODE_OVERLOAD)
    else $error("no overload trip");
  ack_edge_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (fault && $past(ctrl_byte[`CTRL_FAULT_ACK]) && !plant[2]) |=> fault) else $error("level acknowledged");

  // Start, ramp completion and stop requests, each seen one cycle before the state moves
  sequence ramp_go_s;
    state == MOT_OFF && setpoint && op_release && !overload && !fault;
  endsequence
  sequence ramp_done_s;
    state == MOT_RAMP && ramp_top && op_release && setpoint && !trip_reached;
  endsequence
  sequence stop_cmd_s;
    power_on_o && op_release && !setpoint && !trip_reached;
  endsequence

  start_ramp_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ramp_go_s |=> state == MOT_RAMP)
    else $error("no start along the ramp");
  setpoint_stop_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    stop_cmd_s |=> state == MOT_OFF)
    else $error("no stop on setpoint clear");
  ramp_run_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ramp_done_s |=> state == MOT_RUN ##0 status_byte[`ST_RAMP_TOP])
    else $error("ramp top not reported");
  top_rise_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $rose(ramp_top) |-> $past(state) == MOT_RAMP && $past(ramp_cnt) == 32'(RAMP_CYCLES - 1))
    else $error("ramp top too early");
  limit_ramp_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state != MOT_RAMP |-> !status_byte[`ST_CUR_LIMIT])
    else $error("limit bit outside ramp");
  limit_shown_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (plant[1] && param_681 && state == MOT_RAMP) |-> status_byte[`ST_CUR_LIMIT])
    else $error("limit bit missing");
  error_bit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    plant[2] |=> status_byte[`ST_ERROR])
    else $error("error not reported");
  run_bits_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    power_on_o |-> status_byte[`ST_SWITCHED_ON] && status_byte[`ST_POWER])
    else $error("run bits missing");
  trip_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state == MOT_TRIP && !release_ok) |=> state == MOT_TRIP ##0 !power_on_o)
    else $error("left trip too early");
  code_clear_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state == MOT_TRIP && release_ok) |=> in_byte1[6:4] == 3'h0)
    else $error("trip code not cleared");
  op_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state == MOT_OFF && !op_release) |=> !power_on_o)
    else $error("start without release");
  ack_clear_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (fault && ack_rise && !plant[2]) |=> !fault)
    else $error("edge not acknowledged");
  in0_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (wb_ack_o && $past(wb_adr_i) == `OFS_IN_BYTE0 && !$past(wb_we_i)) |-> wb_dat_o == 32'h0000_0000)
    else $error("input byte 0 not zero");
endmodule // starter_overload_process_io

// File: verilog/starter_pkg.sv
// Types shared by the soft-starter process-data block.
// Constants live in starter_defines.svh.
package starter_pkg;
  typedef enum logic [3:0] {
    MOT_OFF = 4'b0001,
    MOT_RAMP = 4'b0010,
    MOT_RUN = 4'b0100,
    MOT_TRIP = 4'b1000
  } motor_state_t;
endpackage
